// ==== shared/cah_pkg.sv ====
// Overview of operation
// R1: consist address register, low seven bits 1..127
// R2: top bit set means backwards-facing, invert direction
// R3: zero value disables consist operation
// R4: consist active: take speed/direction from consist
// R5: consist active: ignore own speed/direction, rest obeyed
// R6: discard programming commands on consist address
// R7: low mask gates F1..F8, bit 0 F1
// R8: high mask gates headlights and F9..F12
// R9: masks only apply while consist active
// R10: own address commands control every function
// R11: consist function command updates masked bits only
// R12: accel rate is baseline plus signed offset
// R13: brake rate is baseline plus signed offset
// R14: consist inactive: baseline rates used unchanged
// R15: offsets are sign-magnitude, 128 means zero
// R16: sum above 255 saturates to 255
// R17: negative sum saturates to 0
// R18: larger rate means slower throttle response
package cah_pkg;
  // ****************************************
  // register offsets and layout
  // ****************************************
  localparam logic [7:0] OFS_CONSIST_ADDR   = 8'h13;
  localparam logic [7:0] OFS_MASK_LOW       = 8'h15;
  localparam logic [7:0] OFS_MASK_HIGH      = 8'h16;
  localparam logic [7:0] OFS_ACCEL_OFFSET   = 8'h17;
  localparam logic [7:0] OFS_BRAKE_OFFSET   = 8'h18;
  localparam logic [7:0] RST_REG            = 8'h00;
  localparam int         POS_REVERSED       = 7;
  localparam int         POS_SIGN           = 7;
  localparam logic [6:0] ADDR_NONE          = 7'h00;
  localparam logic [7:0] RATE_MAX           = 8'hFF;
  localparam logic [7:0] RATE_MIN           = 8'h00;
  // function vector: bit0 headlight fwd, bit1 headlight rev, bits 2..13 F1..F12
  localparam int         FN_W               = 14;
  localparam logic [5:0] MASK_HIGH_USED     = 6'h3F;
  // command kinds delivered by the packet decoder
  typedef enum logic [1:0] {CAH_CMD_SPEED, CAH_CMD_FUNC, CAH_CMD_PROG, CAH_CMD_OTHER} cah_cmd_t;
endpackage : cah_pkg

// ==== logic/cah_consist.sv ====
`timescale 1ns/100ps
module cah_consist
(
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // register port
  input  wire logic            i_reg_wr,
  input  wire logic [7:0]      i_reg_ofs,
  input  wire logic [7:0]      i_reg_wdata,
  output logic      [7:0]      o_reg_rdata,
  // decoded packet
  input  wire logic            i_pkt_valid,
  input  wire logic            i_pkt_to_consist,
  input  wire cah_pkg::cah_cmd_t i_pkt_cmd,
  input  wire logic [7:0]      i_pkt_speed,
  input  wire logic            i_pkt_dir_fwd,
  input  wire logic [13:0]     i_pkt_fn_val,
  input  wire logic [13:0]     i_pkt_fn_sel,
  // baseline rates
  input  wire logic [7:0]      i_base_accel,
  input  wire logic [7:0]      i_base_brake,
  // results
  output logic                 o_consist_active,
  output logic [6:0]           o_consist_addr,
  output logic [7:0]           o_speed,
  output logic                 o_dir_fwd,
  output logic [13:0]          o_fn_state,
  output logic                 o_prog_accept,
  output logic                 o_other_accept,
  output logic [7:0]           o_accel_rate,
  output logic [7:0]           o_brake_rate
);
  import cah_pkg::*;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] consist_address_r;
  logic [7:0] mask_low_r;
  logic [7:0] mask_high_r;
  logic [7:0] accel_offset_r;
  logic [7:0] brake_offset_r;

  // written from the register port, one byte per offset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      consist_address_r <= RST_REG;
      mask_low_r        <= RST_REG;
      mask_high_r       <= RST_REG;
      accel_offset_r    <= RST_REG;
      brake_offset_r    <= RST_REG;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_ofs)
        OFS_CONSIST_ADDR: consist_address_r <= i_reg_wdata; // see R1
        OFS_MASK_LOW:     mask_low_r        <= i_reg_wdata; // see R7
        OFS_MASK_HIGH:    mask_high_r       <= i_reg_wdata; // see R8
        OFS_ACCEL_OFFSET: accel_offset_r    <= i_reg_wdata;
        OFS_BRAKE_OFFSET: brake_offset_r    <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // readback, registered so the output is a flip-flop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= RST_REG;
    else
    begin
      case (i_reg_ofs)
        OFS_CONSIST_ADDR: o_reg_rdata <= consist_address_r;
        OFS_MASK_LOW:     o_reg_rdata <= mask_low_r;
        OFS_MASK_HIGH:    o_reg_rdata <= mask_high_r;
        OFS_ACCEL_OFFSET: o_reg_rdata <= accel_offset_r;
        OFS_BRAKE_OFFSET: o_reg_rdata <= brake_offset_r;
        default:          o_reg_rdata <= RST_REG;
      endcase
    end
  end

  // ****************************************
  // consist state decode
  // ****************************************
  logic        active;
  logic        reversed;
  logic [13:0] fn_mask;

  // zero low address is off; 128 alone is also no valid address
  assign active   = consist_address_r[6:0] != ADDR_NONE;          // see R3
  assign reversed = consist_address_r[POS_REVERSED];              // see R2
  // mask layout: headlights then F1..F8 then F9..F12
  assign fn_mask  = {mask_high_r[5:2], mask_low_r, mask_high_r[1:0]};

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_consist_active <= 1'b0;
      o_consist_addr   <= ADDR_NONE;
    end
    else
    begin
      o_consist_active <= active;
      o_consist_addr   <= active ? consist_address_r[6:0] : ADDR_NONE;
    end
  end

  // with consist off the outputs show no address at all
  chk_addr_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R3
    !active |=> (!o_consist_active && o_consist_addr == ADDR_NONE)) else $error("inactive consist shows address");
  // the top bit is direction only and never leaks into the address
  chk_addr_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R1
    active |=> (o_consist_active && ({1'b0, o_consist_addr} == ($past(consist_address_r) & 8'h7F))))
    else $error("consist address not shown");

  // ****************************************
  // packet handling
  // ****************************************
  logic speed_take;
  logic fn_own;
  logic fn_con;

  // one decode of packet kind, shared by the speed, function, programming and other-instruction logic below
  function automatic logic cah_pkt_is(input logic valid, input cah_cmd_t cmd, input cah_cmd_t kind);
    cah_pkt_is = valid && (cmd == kind);
  endfunction : cah_pkt_is

  // overwrite only the selected function bits; the rest keep their state
  function automatic logic [13:0] cah_fn_merge(input logic [13:0] cur, input logic [13:0] val,
                                               input logic [13:0] sel);
    cah_fn_merge = (cur & ~sel) | (val & sel);
  endfunction : cah_fn_merge

  // speed comes from exactly one address depending on the mode
  assign speed_take = cah_pkt_is(i_pkt_valid, i_pkt_cmd, CAH_CMD_SPEED) &&
                      (active ? i_pkt_to_consist : !i_pkt_to_consist); // see R4, R5
  // a consist-address packet with consist off is not ours at all
  assign fn_own = cah_pkt_is(i_pkt_valid, i_pkt_cmd, CAH_CMD_FUNC) && !i_pkt_to_consist; // see R10
  assign fn_con = cah_pkt_is(i_pkt_valid, i_pkt_cmd, CAH_CMD_FUNC) && i_pkt_to_consist && active; // see R9

  // speed and direction, flipped for a backwards unit
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_speed   <= 8'h00;
      o_dir_fwd <= 1'b1;
    end
    else if (speed_take)
    begin
      o_speed   <= i_pkt_speed;
      o_dir_fwd <= (i_pkt_to_consist && reversed) ? !i_pkt_dir_fwd : i_pkt_dir_fwd; // see R2
    end
  end

  // consist packets with consist off leave speed and direction alone
  chk_speed_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R3
    (!active && i_pkt_valid && i_pkt_to_consist) |=> ($stable(o_speed) && $stable(o_dir_fwd)))
    else $error("consist speed used while inactive");
  // a forward-facing unit passes the commanded direction through
  chk_dir_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R2
    (speed_take && !(i_pkt_to_consist && reversed)) |=> o_dir_fwd == $past(i_pkt_dir_fwd))
    else $error("direction flipped for forward unit");

  // function states; consist packets touch only masked, selected bits
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_fn_state <= 14'h0000;
    else if (fn_own)
      o_fn_state <= cah_fn_merge(o_fn_state, i_pkt_fn_val, i_pkt_fn_sel);           // see R10
    else if (fn_con)
      o_fn_state <= cah_fn_merge(o_fn_state, i_pkt_fn_val, i_pkt_fn_sel & fn_mask); // see R11, R7, R8
  end

  // own-address command writes every selected bit, mask or not
  chk_own_fn: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
    fn_own |=> (o_fn_state & $past(i_pkt_fn_sel)) == ($past(i_pkt_fn_val) & $past(i_pkt_fn_sel)))
    else $error("own function command not applied");
  // bits that the packet does not carry never move
  chk_fn_unsel: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
    fn_own |=> ((o_fn_state ^ $past(o_fn_state)) & ~$past(i_pkt_fn_sel)) == 14'h0000)
    else $error("unselected function changed");
  // consist command writes the bits that are both selected and masked
  chk_fn_applied: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R11
    fn_con |=> (o_fn_state & $past(i_pkt_fn_sel) & $past(fn_mask))
      == ($past(i_pkt_fn_val) & $past(i_pkt_fn_sel) & $past(fn_mask)))
    else $error("masked function not applied");

  // programming only via own address; other instructions always obeyed there
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prog_accept  <= 1'b0;
      o_other_accept <= 1'b0;
    end
    else
    begin
      o_prog_accept  <= cah_pkt_is(i_pkt_valid, i_pkt_cmd, CAH_CMD_PROG) && !i_pkt_to_consist; // see R6
      o_other_accept <= cah_pkt_is(i_pkt_valid, i_pkt_cmd, CAH_CMD_OTHER) && !i_pkt_to_consist; // see R5
    end
  end

  // an own-address instruction other than speed is always obeyed
  chk_other_own: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R5
    (i_pkt_valid && i_pkt_cmd == CAH_CMD_OTHER && !i_pkt_to_consist) |=> o_other_accept)
    else $error("own instruction dropped");
  // programming on the own address is always taken
  chk_prog_own: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R6
    (i_pkt_valid && i_pkt_cmd == CAH_CMD_PROG && !i_pkt_to_consist) |=> o_prog_accept)
    else $error("own programming dropped");

  // ****************************************
  // rate arithmetic
  // ****************************************
  // sign-magnitude add with clamp; larger result means slower response
  function automatic logic [7:0] cah_rate(input logic [7:0] base, input logic [7:0] ofs);
    logic [9:0] sum;
    sum = 10'h000;
    if (ofs[POS_SIGN])                                             // see R15
      sum = {2'b00, base} - {3'b000, ofs[6:0]};
    else
      sum = {2'b00, base} + {3'b000, ofs[6:0]};
    if (sum[9])
      cah_rate = RATE_MIN;                                         // see R17
    else if (sum[8])
      cah_rate = RATE_MAX;                                         // see R16
    else
      cah_rate = sum[7:0];
  endfunction : cah_rate

  // inactive consist passes baselines straight through
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_accel_rate <= RATE_MIN;
      o_brake_rate <= RATE_MIN;
    end
    else
    begin
      o_accel_rate <= active ? cah_rate(i_base_accel, accel_offset_r) : i_base_accel; // see R12, R14, R18
      o_brake_rate <= active ? cah_rate(i_base_brake, brake_offset_r) : i_base_brake; // see R13, R14
    end
  end

  // brake follows the same pass-through as accel
  chk_brake_inactive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R14
    !active |=> o_brake_rate == $past(i_base_brake)) else $error("brake not baseline when inactive");
  // a large positive offset must not wrap round to a fast rate
  chk_brake_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R16
    (active && !brake_offset_r[7] && ({1'b0, i_base_brake} + {2'b00, brake_offset_r[6:0]} > 9'd255))
    |=> o_brake_rate == 8'hFF) else $error("brake not clamped high");
  // a large negative offset must not wrap round to a slow rate
  chk_accel_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R17
    (active && accel_offset_r[7] && (i_base_accel < {1'b0, accel_offset_r[6:0]}))
    |=> o_accel_rate == 8'h00) else $error("accel not clamped low");
  // sign bit with zero magnitude is plain zero
  chk_brake_sum: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R13
    (active && brake_offset_r == 8'h80) |=> o_brake_rate == $past(i_base_brake))
    else $error("zero offset changed brake");
  // positive offset never quickens the response, negative never slows it
  chk_accel_slower: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R18
    (active && !accel_offset_r[POS_SIGN]) |=> o_accel_rate >= $past(i_base_accel))
    else $error("positive offset quickened accel");
  chk_accel_quicker: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R15
    (active && accel_offset_r[POS_SIGN]) |=> o_accel_rate <= $past(i_base_accel))
    else $error("negative offset slowed accel");

  // ****************************************
  // checks
  // ****************************************
  chk_rate_inactive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R14
    !active |=> o_accel_rate == $past(i_base_accel)) else $error("accel not baseline when inactive");
  chk_rate_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R16
    (active && !accel_offset_r[7] && ({1'b0, i_base_accel} + {2'b00, accel_offset_r[6:0]} > 9'd255))
    |=> o_accel_rate == 8'hFF) else $error("accel not clamped high");
  chk_rate_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R17
    (active && brake_offset_r[7] && (i_base_brake < {1'b0, brake_offset_r[6:0]}))
    |=> o_brake_rate == 8'h00) else $error("brake not clamped low");
  chk_accel_sum: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R12
    (active && accel_offset_r == 8'h80) |=> o_accel_rate == $past(i_base_accel))
    else $error("zero offset changed accel");
  chk_dir_invert: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R2
    (speed_take && i_pkt_to_consist && reversed) |=> o_dir_fwd != $past(i_pkt_dir_fwd))
    else $error("backwards unit not inverted");
  chk_own_speed: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R5
    (active && i_pkt_valid && i_pkt_cmd == CAH_CMD_SPEED && !i_pkt_to_consist) |=> $stable(o_speed))
    else $error("own speed taken in consist");
  chk_prog_consist: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R6
    (i_pkt_valid && i_pkt_to_consist) |=> !o_prog_accept) else $error("programming on consist");
  chk_fn_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R11
    fn_con |=> ((o_fn_state ^ $past(o_fn_state)) & ~$past(fn_mask)) == 14'h0000)
    else $error("unmasked function changed");
  chk_fn_inactive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R9
    (!active && i_pkt_valid && i_pkt_to_consist) |=> $stable(o_fn_state))
    else $error("consist function used while inactive");
  chk_consist_spd: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R4
    (active && i_pkt_valid && i_pkt_cmd == CAH_CMD_SPEED && i_pkt_to_consist)
    |=> o_speed == $past(i_pkt_speed)) else $error("consist speed not taken");
endmodule : cah_consist

// ==== tb/cah_station.sv ====
`timescale 1ns/100ps
// ****************************************
// command station: one decoded packet per call
// ****************************************
module cah_station
(
  input  wire logic        i_clk,
  output logic             o_pkt_valid,
  output logic             o_pkt_to_consist,
  output cah_pkg::cah_cmd_t o_pkt_cmd,
  output logic [7:0]       o_pkt_speed,
  output logic             o_pkt_dir_fwd,
  output logic [13:0]      o_pkt_fn_val,
  output logic [13:0]      o_pkt_fn_sel
);
  import cah_pkg::*;
  // lines idle low before the first packet, except the command kind, which idles as CAH_CMD_OTHER
  initial
  begin
    o_pkt_valid = 1'b0;
    o_pkt_to_consist = 1'b0;
    o_pkt_cmd = CAH_CMD_OTHER;
    o_pkt_speed = 8'h00;
    o_pkt_dir_fwd = 1'b0;
    o_pkt_fn_val = 14'h0000;
    o_pkt_fn_sel = 14'h0000;
  end
  // present for one edge, then scramble so stale fields never pass for a packet
  task automatic send(input logic tc, input cah_cmd_t c, input logic [7:0] s, input logic d,
                      input logic [13:0] v, input logic [13:0] m);
    @(posedge i_clk);
    #1;
    o_pkt_valid = 1'b1;
    o_pkt_to_consist = tc;
    o_pkt_cmd = c;
    o_pkt_speed = s;
    o_pkt_dir_fwd = d;
    o_pkt_fn_val = v;
    o_pkt_fn_sel = m;
    @(posedge i_clk);
    #1;
    o_pkt_valid = 1'b0;
    o_pkt_to_consist = ~tc;
    o_pkt_speed = ~s;
    o_pkt_dir_fwd = ~d;
    o_pkt_fn_val = ~v;
    o_pkt_fn_sel = ~m;
  endtask : send
endmodule : cah_station

// ==== tb/consist_address_handler_tb.sv ====
`timescale 1ns/100ps
module consist_address_handler_tb;
  import cah_pkg::*;
  logic        clk, rst_n, wr, pv, ptc, pdir, act, dir, pa, oa;
  logic [7:0]  ofs, wd, rdata, spd, acc, brk, ba, bb, ao, bo, lo, hi, d;
  logic [13:0] fn, fn_e, v, s, m, pval, psel;
  logic [7:0]  pspd;
  logic [6:0]  caddr;
  cah_cmd_t    pcmd;
  int          seed, err_count, checks_done;
  logic [7:0]  offs [6] = '{OFS_CONSIST_ADDR, OFS_MASK_LOW, OFS_MASK_HIGH, OFS_ACCEL_OFFSET, OFS_BRAKE_OFFSET, 8'h14};
  cah_station st (.i_clk(clk), .o_pkt_valid(pv), .o_pkt_to_consist(ptc), .o_pkt_cmd(pcmd), .o_pkt_speed(pspd),
                  .o_pkt_dir_fwd(pdir), .o_pkt_fn_val(pval), .o_pkt_fn_sel(psel));
  cah_consist dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_ofs(ofs), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .i_pkt_valid(pv), .i_pkt_to_consist(ptc), .i_pkt_cmd(pcmd), .i_pkt_speed(pspd),
    .i_pkt_dir_fwd(pdir), .i_pkt_fn_val(pval), .i_pkt_fn_sel(psel), .i_base_accel(ba), .i_base_brake(bb),
    .o_consist_active(act), .o_consist_addr(caddr), .o_speed(spd), .o_dir_fwd(dir), .o_fn_state(fn),
    .o_prog_accept(pa), .o_other_accept(oa), .o_accel_rate(acc), .o_brake_rate(brk));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // extra edge at the end lets derived flags settle
  task automatic wreg(input logic [7:0] o, input logic [7:0] x);
    cyc(1);
    wr = 1'b1;
    ofs = o;
    wd = x;
    cyc(1);
    wr = 1'b0;
    wd = ~x;
    cyc(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] o, input logic [7:0] e);
    cyc(1);
    ofs = o;
    cyc(1);
    chk("rdata", e, rdata);
  endtask : rreg
  // mask bits in function vector order
  function automatic logic [13:0] fm(input logic [7:0] l, input logic [7:0] h);
    return {h[5:2], l, h[1:0]};
  endfunction : fm
  function automatic logic [7:0] rt(input logic [7:0] b, input logic [7:0] o);
    int t;
    t = int'(b) + (o[7] ? -int'(o[6:0]) : int'(o[6:0]));
    return (t > 255) ? 8'hFF : (t < 0) ? 8'h00 : 8'(t);
  endfunction : rt
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // watchdog: a hang counts as a mismatch
  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end
  initial
  begin
    seed = 33401;
    err_count = 0;
    checks_done = 0;
    {rst_n, wr, ofs, wd, ba, bb, fn_e} = '0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("dir", 1, dir);
    foreach (offs[i])
    begin
      rreg(offs[i], 8'h00);
      d = 8'($random(seed));
      wreg(offs[i], d);
      rreg(offs[i], (i == 5) ? 8'h00 : d);
    end
    $display("test regs done");
    // address 128 alone still counts as inactive
    wreg(OFS_CONSIST_ADDR, 8'h80);
    ba = 8'($random(seed));
    bb = 8'($random(seed));
    cyc(3);
    chk("active", 0, act);
    chk("accel", ba, acc);
    chk("brake", bb, brk);
    st.send(1'b1, CAH_CMD_SPEED, 8'h33, 1'b0, 0, 0);
    chk("speed", 0, spd);
    st.send(1'b0, CAH_CMD_SPEED, 8'h5A, 1'b0, 0, 0);
    chk("speed", 8'h5A, spd);
    v = 14'($random(seed));
    st.send(1'b1, CAH_CMD_FUNC, 0, 1'b0, v, 14'h3FFF);
    chk("fn", 0, fn);
    st.send(1'b0, CAH_CMD_FUNC, 0, 1'b0, v, 14'h3FFF);
    fn_e = v;
    chk("fn", fn_e, fn);
    $display("test inactive done");
    wreg(OFS_CONSIST_ADDR, 8'h28);
    chk("caddr", 7'h28, caddr);
    st.send(1'b0, CAH_CMD_SPEED, 8'h11, 1'b1, 0, 0);
    chk("speed", 8'h5A, spd);
    st.send(1'b1, CAH_CMD_SPEED, 8'h22, 1'b1, 0, 0);
    chk("speed", 8'h22, spd);
    chk("dir", 1, dir);
    st.send(1'b0, CAH_CMD_OTHER, 0, 1'b0, 0, 0);
    chk("other", 1, oa);
    st.send(1'b1, CAH_CMD_PROG, 0, 1'b0, 0, 0);
    chk("prog", 0, pa);
    st.send(1'b0, CAH_CMD_PROG, 0, 1'b0, 0, 0);
    chk("prog", 1, pa);
    for (int i = 0; i < 6; i++)
    begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      wreg(OFS_MASK_LOW, lo);
      wreg(OFS_MASK_HIGH, hi);
      v = 14'($random(seed));
      s = (i == 0) ? 14'h3FFF : 14'($random(seed));
      m = fm(lo, hi) & s;
      fn_e = (fn_e & ~m) | (v & m);
      st.send(1'b1, CAH_CMD_FUNC, 0, 1'b0, v, s);
      chk("fn", fn_e, fn);
    end
    wreg(OFS_CONSIST_ADDR, 8'hA8);
    st.send(1'b1, CAH_CMD_SPEED, 8'h44, 1'b1, 0, 0);
    chk("dir", 0, dir);
    $display("test active done");
    for (int i = 0; i < 10; i++)
    begin
      ba = (i == 0) ? 8'd250 : (i == 1) ? 8'd3 : 8'($random(seed));
      ao = (i == 0) ? 8'h0A : (i == 1) ? 8'h85 : (i == 2) ? 8'h80 : 8'($random(seed));
      bo = (i < 3) ? ao : 8'($random(seed));
      bb = (i < 2) ? ba : 8'($random(seed));
      wreg(OFS_ACCEL_OFFSET, ao);
      wreg(OFS_BRAKE_OFFSET, bo);
      cyc(2);
      chk("accel", rt(ba, ao), acc);
      chk("brake", rt(bb, bo), brk);
    end
    wreg(OFS_CONSIST_ADDR, 8'h00);
    cyc(2);
    chk("active", 0, act);
    chk("accel", ba, acc);
    $display("test rates done");
    // mid-run reset drops the consist and all commanded state
    wreg(OFS_CONSIST_ADDR, 8'h28);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    chk("active", 0, act);
    chk("caddr", 7'h00, caddr);
    chk("speed", 0, spd);
    chk("dir", 1, dir);
    chk("fn", 14'h0000, fn);
    rreg(OFS_CONSIST_ADDR, 8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule : consist_address_handler_tb
